// [shared/timer3_cfg.svh]
// Purpose: Offsets, field positions, reset values and divider taps of the timer3 control.
// Assumes: APB byte addresses; every register takes one aligned word.
// Notes:   Included by its bare name.
`ifndef TIMER3_CFG_SVH
`define TIMER3_CFG_SVH

// Register byte offsets.
`define ADDR_CONTROL     4'h0
`define ADDR_PERIOD      4'h4
`define ADDR_PULSE_WIDTH 4'h8
`define ADDR_STATUS      4'hC

// Control register field positions.
`define CTRL_FF_BIT      7
`define CTRL_CK_MSB      6
`define CTRL_CK_LSB      4
`define CTRL_RUN_BIT     3
`define CTRL_MODE_MSB    2
`define CTRL_MODE_LSB    0

// Reset values.
`define CONTROL_RESET    8'h00
`define PERIOD_RESET     8'h00
`define PULSE_RESET      8'h00

// Mode codes that matter to the control logic.
`define MODE_CASCADE     3'h3
`define T4_MODE_PWM16    3'h6

// Source clock codes and divider taps (powers of two of the fast clock).
`define CK_FC_2_11       3'h0
`define CK_FS            3'h4
`define CK_FC            3'h6
`define CK_PIN           3'h7
`define TAP_11           11
`define TAP_7            7
`define TAP_5            5
`define TAP_3            3
`define TAP_1            1
`define PRESCALE_WIDTH   11
`define FS_DIV_WIDTH     3

`endif

// [shared/timer3_pkg.sv]
// Purpose: Types shared by the timer3 control and its source clock selector.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Numbers live in timer3_cfg.svh.
package timer3_pkg;

	// System operating mode as driven by the power controller.
	typedef enum logic [1:0] {OP_NORMAL, OP_IDLE, OP_SLOW, OP_SLEEP} op_mode_t;

	// Decoded timer3 operating mode.
	typedef enum logic [2:0] {
		MODE_TIMER_EVENT,
		MODE_DIVIDER_OUTPUT,
		MODE_PWM8,
		MODE_CASCADE16,
		MODE_RESERVED
	} mode_t;

endpackage

// [shared/tick_if.sv]
// Purpose: Carries the source clock choice and the resulting count tick between modules.
// Assumes: One clock domain.
// Notes:   The selector drives the tick, the control drives the choice.
`timescale 1ns/10ps
interface tick_if;
	logic [2:0] clk_code;    // Source clock select code.
	logic       slow_mode;   // System runs from the slow clock.
	logic       tap_select;  // Prescaler tap select.
	logic       src_tick;    // One-cycle enable at the chosen rate.
	logic       src_valid;   // Chosen source is usable in this mode.

	modport sel (input clk_code, input slow_mode, input tap_select,
		output src_tick, output src_valid);
	modport ctl (output clk_code, output slow_mode, output tap_select,
		input src_tick, input src_valid);
endinterface

// [hdl/clock_source_select.sv]
// Purpose: Prescaler and source clock selection for timer3 as one-cycle enables.
// Assumes: mclk is the high frequency clock; pins are asynchronous.
// Notes:   Outputs are registered, so a tick lags its cause by one cycle.
`timescale 1ns/10ps
`include "timer3_cfg.svh"
module clock_source_select
	import timer3_pkg::*;
(
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst,
	// Asynchronous pins.
	input  wire logic low_frequency_clock,
	input  wire logic counter_pin,
	// Selection and tick.
	tick_if.sel       tk
);

	logic [`PRESCALE_WIDTH-1:0] pre;       // Free running prescaler.
	logic [`PRESCALE_WIDTH-1:0] next_pre;
	logic [`FS_DIV_WIDTH-1:0]   fs_div;    // Slow clock edge divider.
	logic [`FS_DIV_WIDTH-1:0]   next_fs_div;
	logic [2:0]                 fs_sync;   // Sync pair plus edge history.
	logic [2:0]                 pin_sync;  // Sync pair plus edge history.
	logic                       next_tick;
	logic                       next_valid;
	logic                       fs_edge;
	logic                       pin_edge;

	// True when the low n prescaler bits are all ones, one cycle in 2^n.
	function automatic logic tap_hit(input logic [`PRESCALE_WIDTH-1:0] v, input int n);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < `PRESCALE_WIDTH; i++)
		begin
			if (i < n)
			begin
				hit = hit & v[i];
			end
		end
		return hit;
	endfunction

	// Edges are taken from the second and third stages, never the first.
	assign fs_edge  = fs_sync[1] & ~fs_sync[2];
	assign pin_edge = pin_sync[1] & ~pin_sync[2];

	// Next prescaler, divider and selected tick.
	always_comb
	begin
		next_pre    = pre + 1'b1;
		next_fs_div = fs_edge ? fs_div + 1'b1 : fs_div;
		next_tick   = 1'b0;
		next_valid  = ~tk.slow_mode;
		// [RULE_08] source clock decode
		case (tk.clk_code)
			`CK_FC_2_11:
			begin
				// Slow modes always fall back to the divided slow clock.
				next_valid = 1'b1;
				if (tk.slow_mode | tk.tap_select)
				begin
					next_tick = fs_edge & (&fs_div);
				end
				else
				begin
					next_tick = tap_hit(pre, `TAP_11);
				end
			end
			3'h1: next_tick = tap_hit(pre, `TAP_7);
			3'h2: next_tick = tap_hit(pre, `TAP_5);
			3'h3: next_tick = tap_hit(pre, `TAP_3);
			`CK_FS:
			begin
				next_tick  = fs_edge;
				next_valid = 1'b1;
			end
			3'h5: next_tick = tap_hit(pre, `TAP_1);
			// [RULE_09] warm-up fast clock
			`CK_FC:
			begin
				next_tick  = 1'b1;
				next_valid = 1'b1;
			end
			`CK_PIN:
			begin
				next_tick  = pin_edge;
				next_valid = 1'b1;
			end
			default: next_tick = 1'b0;
		endcase
		// [RULE_09] block unusable codes
		next_tick = next_tick & next_valid;
	end

	// Registers only; synchronisers shift in their pins.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pre          <= '0;
			fs_div       <= '0;
			fs_sync      <= 3'h0;
			pin_sync     <= 3'h0;
			tk.src_tick  <= 1'b0;
			tk.src_valid <= 1'b0;
		end
		else
		begin
			pre          <= next_pre;
			fs_div       <= next_fs_div;
			fs_sync      <= {fs_sync[1:0], low_frequency_clock};
			pin_sync     <= {pin_sync[1:0], counter_pin};
			tk.src_tick  <= next_tick;
			tk.src_valid <= next_valid;
		end
	end

endmodule

// [hdl/timer3_control.sv]
// Purpose: APB register file and control decode of cascadable 8-bit timer3.
// Assumes: Timer4 fields arrive from logic on mclk; pins are asynchronous.
// Notes:   Counting itself is done elsewhere; this block hands it enables.
// Operation
// [RULE_01] One control, two 8-bit timer registers.
// [RULE_02] Period register untouched while running.
// [RULE_03] Pulse width changes only in PWM modes; the code also accepts writes in any mode while stopped.
// [RULE_04] Mode, clock, flip-flop fields frozen while running.
// [RULE_05] Stop keeps fields; start may program them.
// [RULE_06] Cascade needs mode 011; timer4 picks mode.
// [RULE_07] Cascade: own clock, timer4 run and flip-flop.
// [RULE_08] Clock code decode per operating mode.
// [RULE_09] Slow modes: only 000, 100, warm-up 110; the code also accepts pin code 111.
// [RULE_10] Mode decode; top bit set is reserved.
// [RULE_11] Flip-flop initialised from control at start.
`timescale 1ns/10ps
`include "timer3_cfg.svh"
module timer3_control
	import timer3_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [3:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// System state.
	input  wire op_mode_t    op_mode,
	input  wire logic        prescaler_tap_select,
	// Asynchronous pins.
	input  wire logic        low_frequency_clock,
	input  wire logic        counter_pin,
	// Second counter control fields.
	input  wire logic [2:0]  timer4_mode_field,
	input  wire logic        timer4_run_bit,
	input  wire logic        timer4_flipflop_ctrl,
	// Counter controls.
	output logic             count_enable,
	output logic             count_tick,
	output logic             source_valid,
	output mode_t            timer3_mode,
	output logic             cascade_16bit,
	output logic      [2:0]  cascade_mode,
	output logic             timer_flipflop,
	output logic      [7:0]  period_value,
	output logic      [7:0]  pulse_width_value
);

	tick_if tk ();

	logic [7:0]  ctrl;               // Control register image.
	logic [7:0]  next_ctrl;
	logic [7:0]  next_period;
	logic [7:0]  next_pulse;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        next_count_enable;
	logic        next_count_tick;
	logic        next_source_valid;
	mode_t       next_timer3_mode;
	logic        next_cascade;
	logic [2:0]  next_cascade_mode;
	logic        next_flipflop;
	logic        access;             // Access phase completes this edge.
	logic        mapped;             // Address hits a register.
	logic        eff_run;            // Run control after cascade choice.
	logic        eff_ff;             // Flip-flop control after cascade choice.
	logic        fields_locked;      // Mode, clock and flip-flop frozen.
	logic        pwm_allowed;        // Pulse width may change while running.
	logic [7:0]  status;             // Read-only status image.

	// Decode the three-bit mode field.
	function automatic mode_t decode_mode(input logic [2:0] code);
		mode_t m;
		m = MODE_RESERVED;
		case (code)
			3'h0:           m = MODE_TIMER_EVENT;
			3'h1:           m = MODE_DIVIDER_OUTPUT;
			3'h2:           m = MODE_PWM8;
			`MODE_CASCADE:  m = MODE_CASCADE16;
			default:        m = MODE_RESERVED;
		endcase
		return m;
	endfunction

	// Source clock selector; its tick is registered once more here.
	clock_source_select u_src (
		.mclk                (mclk),
		.rst                 (rst),
		.low_frequency_clock (low_frequency_clock),
		.counter_pin         (counter_pin),
		.tk                  (tk)
	);

	// [RULE_07] cascade keeps own clock code
	assign tk.clk_code   = ctrl[`CTRL_CK_MSB:`CTRL_CK_LSB];
	assign tk.slow_mode  = (op_mode == OP_SLOW) || (op_mode == OP_SLEEP);
	assign tk.tap_select = prescaler_tap_select;

	assign access  = psel & penable & pready;
	assign mapped  = (paddr == `ADDR_CONTROL) || (paddr == `ADDR_PERIOD)
		|| (paddr == `ADDR_PULSE_WIDTH) || (paddr == `ADDR_STATUS);

	// Combined control view and write protection terms.
	always_comb
	begin
		next_cascade = (ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_CASCADE);
		// [RULE_07] run and flip-flop from timer4
		eff_run = next_cascade ? timer4_run_bit : ctrl[`CTRL_RUN_BIT];
		eff_ff  = next_cascade ? timer4_flipflop_ctrl : ctrl[`CTRL_FF_BIT];
		fields_locked = ctrl[`CTRL_RUN_BIT] | eff_run;
		// [RULE_03] PWM modes admit rewrites
		pwm_allowed = (decode_mode(ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]) == MODE_PWM8)
			|| (next_cascade && (timer4_mode_field == `T4_MODE_PWM16));
		status = {3'h0, next_cascade, ctrl[`CTRL_MODE_MSB], source_valid,
			timer_flipflop, count_enable};
	end

	// Register file next values; writes land only at the completing edge.
	always_comb
	begin
		next_ctrl   = ctrl;
		next_period = period_value;
		next_pulse  = pulse_width_value;
		if (access && pwrite && mapped)
		begin
			case (paddr)
				`ADDR_CONTROL:
				begin
					// [RULE_05] start programs all fields
					if (!fields_locked)
					begin
						next_ctrl = pwdata[7:0];
					end
					// [RULE_04] only run bit moves
					else
					begin
						next_ctrl[`CTRL_RUN_BIT] = pwdata[`CTRL_RUN_BIT];
					end
				end
				// [RULE_02] period ignored while running
				`ADDR_PERIOD:
				begin
					if (!eff_run)
					begin
						next_period = pwdata[7:0];
					end
				end
				// [RULE_03] pulse width gate
				`ADDR_PULSE_WIDTH:
				begin
					if (!eff_run || pwm_allowed)
					begin
						next_pulse = pwdata[7:0];
					end
				end
				default: next_pulse = pulse_width_value;
			endcase
		end
	end

	// APB answer: one wait cycle, then pready with data or error.
	always_comb
	begin
		next_pready  = psel & penable & ~pready;
		next_pslverr = next_pready & ~mapped;
		next_prdata  = prdata;
		if (next_pready)
		begin
			// [RULE_01] register read back
			case (paddr)
				`ADDR_CONTROL:     next_prdata = {24'h000000, ctrl};
				`ADDR_PERIOD:      next_prdata = {24'h000000, period_value};
				`ADDR_PULSE_WIDTH: next_prdata = {24'h000000, pulse_width_value};
				`ADDR_STATUS:      next_prdata = {24'h000000, status};
				default:           next_prdata = 32'h00000000;
			endcase
		end
	end

	// Counter control outputs.
	always_comb
	begin
		next_count_enable = eff_run;
		next_count_tick   = eff_run & tk.src_tick & tk.src_valid;
		next_source_valid = tk.src_valid;
		// [RULE_10] mode decode
		next_timer3_mode  = decode_mode(ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
		// [RULE_06] timer4 selects 16-bit mode
		next_cascade_mode = next_cascade ? timer4_mode_field : 3'h0;
		next_flipflop     = timer_flipflop;
		// [RULE_11] initialise at start
		if (eff_run && !count_enable)
		begin
			next_flipflop = eff_ff;
		end
	end

	// Registers only.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctrl              <= `CONTROL_RESET;
			period_value      <= `PERIOD_RESET;
			pulse_width_value <= `PULSE_RESET;
			prdata            <= 32'h00000000;
			pready            <= 1'b0;
			pslverr           <= 1'b0;
			count_enable      <= 1'b0;
			count_tick        <= 1'b0;
			source_valid      <= 1'b0;
			timer3_mode       <= MODE_TIMER_EVENT;
			cascade_16bit     <= 1'b0;
			cascade_mode      <= 3'h0;
			timer_flipflop    <= 1'b0;
		end
		else
		begin
			ctrl              <= next_ctrl;
			period_value      <= next_period;
			pulse_width_value <= next_pulse;
			prdata            <= next_prdata;
			pready            <= next_pready;
			pslverr           <= next_pslverr;
			count_enable      <= next_count_enable;
			count_tick        <= next_count_tick;
			source_valid      <= next_source_valid;
			timer3_mode       <= next_timer3_mode;
			cascade_16bit     <= next_cascade;
			cascade_mode      <= next_cascade_mode;
			timer_flipflop    <= next_flipflop;
		end
	end

	// Checks.
	property p_period_write;
		@(posedge mclk) disable iff (rst)
		(access && pwrite && paddr == `ADDR_PERIOD && !eff_run)
			|=> period_value == $past(pwdata[7:0]);
	endproperty
	a_period_write: assert property (p_period_write) else $error("period not loaded"); // [RULE_01]

	property p_period_locked;
		@(posedge mclk) disable iff (rst) eff_run |=> $stable(period_value);
	endproperty
	a_period_locked: assert property (p_period_locked) else $error("period moved"); // [RULE_02]

	property p_pulse_locked;
		@(posedge mclk) disable iff (rst)
		(eff_run && !pwm_allowed) |=> $stable(pulse_width_value);
	endproperty
	a_pulse_locked: assert property (p_pulse_locked) else $error("pulse moved"); // [RULE_03]

	property p_fields_locked;
		@(posedge mclk) disable iff (rst)
		fields_locked |=> ({ctrl[7:4], ctrl[2:0]} == $past({ctrl[7:4], ctrl[2:0]}));
	endproperty
	a_fields_locked: assert property (p_fields_locked) else $error("field moved"); // [RULE_04]

	property p_start_programs;
		@(posedge mclk) disable iff (rst)
		(access && pwrite && paddr == `ADDR_CONTROL && !fields_locked)
			|=> ctrl == $past(pwdata[7:0]);
	endproperty
	a_start_programs: assert property (p_start_programs) else $error("start lost"); // [RULE_05]

	property p_cascade_mode;
		@(posedge mclk) disable iff (rst)
		(ctrl[2:0] == `MODE_CASCADE)
			|=> cascade_16bit && cascade_mode == $past(timer4_mode_field);
	endproperty
	a_cascade_mode: assert property (p_cascade_mode) else $error("cascade mode"); // [RULE_06]

	property p_cascade_run;
		@(posedge mclk) disable iff (rst)
		(ctrl[2:0] == `MODE_CASCADE) |=> count_enable == $past(timer4_run_bit);
	endproperty
	a_cascade_run: assert property (p_cascade_run) else $error("cascade run"); // [RULE_07]

	property p_fast_tick;
		@(posedge mclk) disable iff (rst)
		(eff_run && ctrl[6:4] == `CK_FC && !tk.slow_mode)[*3] |-> count_tick;
	endproperty
	a_fast_tick: assert property (p_fast_tick) else $error("no fast tick"); // [RULE_08]

	property p_slow_block;
		@(posedge mclk) disable iff (rst)
		(tk.slow_mode && ctrl[6:4] != `CK_FC_2_11 && ctrl[6:4] != `CK_FS
			&& ctrl[6:4] != `CK_FC && ctrl[6:4] != `CK_PIN)[*2]
			|=> !count_tick && !source_valid;
	endproperty
	a_slow_block: assert property (p_slow_block) else $error("slow code ticked"); // [RULE_09]

	property p_reserved;
		@(posedge mclk) disable iff (rst) ctrl[2] |=> timer3_mode == MODE_RESERVED;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode"); // [RULE_10]

	property p_ff_init;
		@(posedge mclk) disable iff (rst)
		(eff_run && !count_enable) |=> timer_flipflop == $past(eff_ff);
	endproperty
	a_ff_init: assert property (p_ff_init) else $error("flip-flop init"); // [RULE_11]

	c_start:   cover property (@(posedge mclk) disable iff (rst) eff_run && !count_enable);
	c_cascade: cover property (@(posedge mclk) disable iff (rst) cascade_16bit && count_enable);
	c_slow:    cover property (@(posedge mclk) disable iff (rst) tk.slow_mode && count_tick);
	c_read:    cover property (@(posedge mclk) disable iff (rst) access && !pwrite);

endmodule

// [sim/testbench.sv]
// Purpose: Self-checking bench for the timer3 control block over APB.
// Assumes: The slave answers after one wait state; side inputs are synchronous to mclk.
// Notes:   Random data comes from a fixed seed, so every run repeats exactly.
`timescale 1ns/10ps
`include "timer3_cfg.svh"
module testbench
	import timer3_pkg::*;
;
	// Clock, reset and APB request.
	logic        mclk, rst, psel, penable, pwrite;
	logic [3:0]  paddr;
	logic [31:0] pwdata;
	// Side inputs that the bench drives.
	op_mode_t    op_mode;
	logic        prescaler_tap_select;
	logic        low_frequency_clock = 1'b0;  // Only the slow-clock process drives it.
	logic        counter_pin = 1'b0;          // Only the slow-clock process drives it.
	logic [2:0]  timer4_mode_field;
	logic        timer4_run_bit, timer4_flipflop_ctrl;
	// Design outputs.
	logic [31:0] prdata;
	logic        pready, pslverr, count_enable, count_tick, source_valid;
	mode_t       timer3_mode;
	logic        cascade_16bit, timer_flipflop;
	logic [2:0]  cascade_mode;
	logic [7:0]  period_value, pulse_width_value;
	// Bench bookkeeping.
	int          err_total, total_checks;
	logic [7:0]  lf_div = 8'h00;              // Starts at zero so both pins idle low.
	logic [31:0] rd;
	logic        er;
	logic [7:0]  pv, wv;
	int          cnt;
	// The slow clock has a period of 16 cycles and the pin one of 8, hence shifts 4 and 3.
	int          tcode[9] = '{0, 1, 2, 3, 5, 6, 0, 4, 7};
	int          tshift[9] = '{11, 7, 5, 3, 1, 0, 7, 4, 3};

	timer3_control DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.op_mode(op_mode), .prescaler_tap_select(prescaler_tap_select),
		.low_frequency_clock(low_frequency_clock), .counter_pin(counter_pin),
		.timer4_mode_field(timer4_mode_field), .timer4_run_bit(timer4_run_bit),
		.timer4_flipflop_ctrl(timer4_flipflop_ctrl), .count_enable(count_enable),
		.count_tick(count_tick), .source_valid(source_valid), .timer3_mode(timer3_mode),
		.cascade_16bit(cascade_16bit), .cascade_mode(cascade_mode),
		.timer_flipflop(timer_flipflop), .period_value(period_value),
		.pulse_width_value(pulse_width_value));

	// Free-running clock at 25 MHz.
	always #20 mclk = ~mclk;

	// The slow clock is mclk/16 and the pin mclk/8, so slow-clock ticks have a known period.
	always @(posedge mclk)
	begin
		lf_div              <= lf_div + 8'h01;
		low_frequency_clock <= lf_div[3];
		counter_pin         <= lf_div[2];
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compares with case equality so an unknown never matches.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// A slave that never answers would hang the bench, so the wait is bounded.
		if (n == 20)
		begin
			err_total++;
			$display("mismatch at %0t: no pready", $time);
			end_sim();
		end
	endtask

	// Reads a register and compares the whole word.
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rd, {24'h000000, exp}, "read data");
	endtask

	// Packs the control byte: flip-flop, clock code, run, mode.
	function automatic logic [7:0] ctl(input logic f, input int ck, input logic r, input int m);
		return {f, 3'(ck), r, 3'(m)};
	endfunction

	// Divided fast-clock codes other than 000 are unusable in the slow operating modes.
	function automatic logic exp_valid(input int op, input int ck);
		return !((op >= 2) && (ck == 1 || ck == 2 || ck == 3 || ck == 5));
	endfunction

	// Any mode code with its top bit set decodes to the reserved mode.
	function automatic mode_t exp_mode(input int m);
		return (m > 3) ? MODE_RESERVED : mode_t'(m);
	endfunction

	// Main sequence.
	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 4'h0;
		pwdata = 32'h00000000;
		op_mode = OP_NORMAL;
		prescaler_tap_select = 1'b0;
		timer4_run_bit = 1'b0;
		timer4_flipflop_ctrl = 1'b0;
		err_total = 0;
		total_checks = 0;
		void'($urandom(32'h6ceef646));
		timer4_mode_field = 3'($urandom);
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rdchk(`ADDR_CONTROL, `CONTROL_RESET);
		chk(er, 1'b0, "mapped error");
		rdchk(`ADDR_PERIOD, `PERIOD_RESET);
		rdchk(`ADDR_PULSE_WIDTH, `PULSE_RESET);
		// An unaligned offset must be refused with an error and zero data.
		apb(1'b0, 4'h2, 8'h00);
		chk(er, 1'b1, "unmapped error");
		chk(rd, 32'h00000000, "unmapped data");
		// Random register contents while stopped, four rounds of random patterns.
		repeat (4)
		begin
			pv = 8'($urandom);
			wv = 8'($urandom);
			apb(1'b1, `ADDR_PERIOD, pv);
			apb(1'b1, `ADDR_PULSE_WIDTH, wv);
			rdchk(`ADDR_PERIOD, pv);
			rdchk(`ADDR_PULSE_WIDTH, wv);
			chk(period_value, pv, "period out");
			chk(pulse_width_value, wv, "pulse out");
		end
		// Every mode code, stopped, with the cascade view of the second counter.
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, `ADDR_CONTROL, ctl(1'b0, 6, 1'b0, m));
			repeat (3) @(posedge mclk);
			chk(timer3_mode, exp_mode(m), "mode decode");
			chk(cascade_16bit, m == 3, "cascade flag");
			chk(cascade_mode, (m == 3) ? timer4_mode_field : 3'h0, "cascade mode");
		end
		// Usability of every clock code in every operating mode.
		for (int op = 0; op < 4; op++)
			for (int ck = 0; ck < 8; ck++)
			begin
				op_mode <= op_mode_t'(op);
				apb(1'b1, `ADDR_CONTROL, ctl(1'b0, ck, 1'b0, 0));
				repeat (3) @(posedge mclk);
				chk(source_valid, exp_valid(op, ck), "source valid");
			end
		op_mode <= OP_NORMAL;
		// Start with each flip-flop level, then try forbidden writes while running.
		for (int f = 0; f < 2; f++)
		begin
			apb(1'b1, `ADDR_CONTROL, ctl(f[0], 6, 1'b1, 0));
			repeat (3) @(posedge mclk);
			chk(count_enable, 1'b1, "run");
			chk(timer_flipflop, f[0], "flip-flop start");
			chk(count_tick, 1'b1, "fast tick");
			apb(1'b1, `ADDR_PERIOD, ~pv);
			rdchk(`ADDR_PERIOD, pv);
			apb(1'b1, `ADDR_PULSE_WIDTH, ~wv);
			rdchk(`ADDR_PULSE_WIDTH, wv);
			apb(1'b1, `ADDR_CONTROL, ctl(~f[0], 2, 1'b1, 1));
			rdchk(`ADDR_CONTROL, ctl(f[0], 6, 1'b1, 0));
			apb(1'b1, `ADDR_CONTROL, ctl(~f[0], 2, 1'b0, 1));
			rdchk(`ADDR_CONTROL, ctl(f[0], 6, 1'b0, 0));
			repeat (3) @(posedge mclk);
			chk(count_enable, 1'b0, "stopped");
			chk(timer_flipflop, f[0], "flip-flop holds");
		end
		// Tick rate of each source, slow clock and pin too: four periods hold four ticks.
		for (int i = 0; i < 9; i++)
		begin
			prescaler_tap_select <= (i == 6);
			apb(1'b1, `ADDR_CONTROL, ctl(1'b0, tcode[i], 1'b1, 0));
			repeat (8) @(posedge mclk);
			cnt = 0;
			repeat (4 << tshift[i])
			begin
				@(posedge mclk);
				cnt += (count_tick === 1'b1);
			end
			chk(cnt, 4, "tick rate");
			apb(1'b1, `ADDR_CONTROL, ctl(1'b0, tcode[i], 1'b0, 0));
		end
		prescaler_tap_select <= 1'b0;
		// In 8-bit PWM the pulse width may change while running.
		apb(1'b1, `ADDR_CONTROL, ctl(1'b0, 6, 1'b1, 2));
		apb(1'b1, `ADDR_PULSE_WIDTH, ~wv);
		rdchk(`ADDR_PULSE_WIDTH, ~wv);
		apb(1'b1, `ADDR_CONTROL, ctl(1'b0, 6, 1'b0, 2));
		// Cascade: the second counter's run and flip-flop bits take over.
		timer4_mode_field    <= 3'h6;
		timer4_flipflop_ctrl <= 1'b1;
		apb(1'b1, `ADDR_CONTROL, ctl(1'b0, 6, 1'b0, 3));
		repeat (3) @(posedge mclk);
		chk(count_enable, 1'b0, "cascade idle");
		chk(cascade_mode, 3'h6, "cascade mode");
		timer4_run_bit <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(count_enable, 1'b1, "cascade run");
		chk(timer_flipflop, 1'b1, "cascade flip-flop");
		// Status: cascade, no reserved mode, source usable, flip-flop set, running.
		rdchk(`ADDR_STATUS, {3'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1});
		apb(1'b1, `ADDR_PULSE_WIDTH, wv);
		rdchk(`ADDR_PULSE_WIDTH, wv);
		apb(1'b1, `ADDR_PERIOD, ~pv);
		rdchk(`ADDR_PERIOD, pv);
		apb(1'b1, `ADDR_CONTROL, ctl(1'b1, 1, 1'b0, 0));
		rdchk(`ADDR_CONTROL, ctl(1'b0, 6, 1'b0, 3));
		timer4_run_bit <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(count_enable, 1'b0, "cascade stop");
		end_sim();
	end
endmodule
